/* File: cid_params.svh */
// constants for the instruction slice core: bus offsets, field positions,
// opcodes and reset values; included by the core and its testbench
`ifndef CID_PARAMS_SVH
`define CID_PARAMS_SVH

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define CID_CTRL_OFF 12'h000
`define CID_STAT_OFF 12'h004
`define CID_CTRL_RST 32'h0000_0000

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define CID_CTRL_RUN 0
`define CID_CTRL_CY 1
`define CID_CTRL_F0 2
`define CID_CTRL_F1 3
`define CID_CTRL_BANK 4

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define CID_STAT_EXT_EN 8
`define CID_STAT_TMR_EN 9
`define CID_STAT_TMR_PEND 10
`define CID_STAT_TMR_FLAG 11
`define CID_STAT_CLK_OUT 12
`define CID_STAT_PC_LSB 16

// ----------------------------------------------------------------
// full opcodes, and the upper seven bits of the indirect increment
// ----------------------------------------------------------------
`define CID_OP_DEC_A 8'h07
`define CID_OP_INC_A 8'h17
`define CID_OP_EXT_ON 8'h05
`define CID_OP_EXT_OFF 8'h15
`define CID_OP_TMR_ON 8'h25
`define CID_OP_TMR_OFF 8'h35
`define CID_OP_CLK_OUT 8'h75
`define CID_OP_BUS_RD 8'h08
`define CID_OP_PORT1 8'h09
`define CID_OP_PORT2 8'h0A
`define CID_OP_CY_SET 8'hF6
`define CID_OP_CY_CLR 8'hE6
`define CID_OP_F0_BR 8'hB6
`define CID_OP_F1_BR 8'h76
`define CID_OP_IRQ_BR 8'h86
`define CID_OP_TF_BR 8'h16
`define CID_OP_TABLE 8'hB3
`define CID_OP_INC_IND 7'h08

// ----------------------------------------------------------------
// opcode groups: upper five bits, or low five bits
// ----------------------------------------------------------------
`define CID_GRP_DEC_R 5'h19
`define CID_GRP_INC_R 5'h03
`define CID_GRP_COUNT_DOWN_BRANCH 5'h1D
`define CID_LOW_ACC_BIT 5'h12
`define CID_LOW_JUMP 5'h04

`endif

/* File: cid_pkg.sv */
// types shared by the instruction slice core
// assumes cid_params.svh is seen by the files that need the constants
package cid_pkg;

    // ----------------------------------------------------------------
    // machine cycle sequencer
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        CID_CYC1 = 2'b01,
        CID_CYC2 = 2'b10
    } cid_state_e;

    // ----------------------------------------------------------------
    // software-held condition bits
    // ----------------------------------------------------------------
    typedef struct packed {
        logic bank;
        logic f1;
        logic f0;
        logic cy;
        logic run;
    } cid_ctrl_s;

    // ----------------------------------------------------------------
    // interrupt and pin control state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic clk_out;
        logic tmr_flag;
        logic tmr_pend;
        logic tmr_en;
        logic ext_en;
    } cid_irq_s;

endpackage : cid_pkg

/* File: cid_core.sv */
// decode and execute core for one slice of an 8-bit instruction set
// assumes program memory answers combinationally on prog_addr, ports and
// bus inputs synchronous to mclk, and an APB master on the register side
`timescale 1ns/1ps
`include "cid_params.svh"

module cid_core #(
    parameter int RAM_DEPTH = 64,
    parameter int PC_W = 12
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // program memory
    output logic [PC_W-1:0] prog_addr,
    input wire logic [7:0] prog_data,
    // ports and strobed bus
    input wire logic [7:0] port1_in,
    input wire logic [7:0] port2_in,
    input wire logic [7:0] bus_in,
    output logic bus_rd_n,
    // interrupt pin, timer overflow and service handshake
    input wire logic irq_n,
    input wire logic timer_ovf,
    input wire logic irq_ack,
    output logic irq_request,
    // test pin zero, two-way
    input wire logic test_pin_zero_in,
    output logic test_pin_zero_out,
    output logic test_pin_zero_oe,
    // visible state
    output logic [7:0] acc_out
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    cid_pkg::cid_state_e state_r;
    cid_pkg::cid_ctrl_s ctrl_r;
    cid_pkg::cid_irq_s irq_r;
    logic [PC_W-1:0] pc_r;
    logic [PC_W-1:0] pc_inc;
    logic [7:0] op_r;
    logic [7:0] acc_r;
    logic [7:0] ram_r [RAM_DEPTH];
    logic clk_div_r;
    logic [7:0] op;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    logic two_cycle;
    logic is_dec_r;
    logic is_inc_r;
    logic is_count_down_branch;
    logic is_bit_br;
    logic is_jump;
    logic is_inc_ind;
    logic [2:0] reg_sel;
    logic [5:0] ind_addr;
    logic [7:0] reg_val;
    logic [7:0] reg_dec;
    logic cond;
    logic cond_br;
    logic exec1;
    logic exec2;
    logic wr_ctrl;
    logic rd_ok;

    // opcode under execution: live in the first cycle, latched after
    assign op = (state_r == cid_pkg::CID_CYC1) ? prog_data : op_r;
    assign reg_sel = op[2:0];
    assign is_dec_r = (op[7:3] == `CID_GRP_DEC_R);
    assign is_inc_r = (op[7:3] == `CID_GRP_INC_R);
    assign is_count_down_branch = (op[7:3] == `CID_GRP_COUNT_DOWN_BRANCH);
    // any bit number in bits 7-5
    assign is_bit_br = (op[4:0] == `CID_LOW_ACC_BIT);
    assign is_jump = (op[4:0] == `CID_LOW_JUMP);
    assign is_inc_ind = (op[7:1] == `CID_OP_INC_IND);
    // pointer is register zero or one, low six bits
    assign ind_addr = ram_r[{2'b00, op[0]}][5:0];
    assign reg_val = ram_r[reg_sel];
    assign reg_dec = reg_val - 8'h01;
    assign pc_inc = {pc_r[PC_W-1], pc_r[PC_W-2:0] + 1'b1};

    always_comb begin
        two_cycle = is_count_down_branch | is_bit_br | is_jump;
        case (op)
            `CID_OP_BUS_RD, `CID_OP_PORT1, `CID_OP_PORT2,
            `CID_OP_CY_SET, `CID_OP_CY_CLR, `CID_OP_F0_BR,
            `CID_OP_F1_BR, `CID_OP_IRQ_BR, `CID_OP_TF_BR,
            `CID_OP_TABLE: two_cycle = 1'b1;
            default: ;
        endcase
    end

    // branch conditions for the conditional group
    always_comb begin
        cond = 1'b0;
        case (op)
            `CID_OP_CY_SET: cond = ctrl_r.cy;
            `CID_OP_CY_CLR: cond = ~ctrl_r.cy;
            `CID_OP_F0_BR: cond = ctrl_r.f0;
            `CID_OP_F1_BR: cond = ctrl_r.f1;
            // pin level only, enable not consulted
            `CID_OP_IRQ_BR: cond = ~irq_n;
            `CID_OP_TF_BR: cond = irq_r.tmr_flag;
            default: cond = 1'b0;
        endcase
        if (is_bit_br) begin
            // tested bit from opcode bits 7-5
            cond = acc_r[op[7:5]];
        end
        if (is_count_down_branch) begin
            cond = (reg_val != 8'h01);
        end
    end
    assign cond_br = is_bit_br | is_count_down_branch | (op == `CID_OP_CY_SET)
        | (op == `CID_OP_CY_CLR) | (op == `CID_OP_F0_BR)
        | (op == `CID_OP_F1_BR) | (op == `CID_OP_IRQ_BR)
        | (op == `CID_OP_TF_BR);

    // halting through the control register freezes the core between ops
    assign exec1 = (state_r == cid_pkg::CID_CYC1) & ctrl_r.run;
    assign exec2 = (state_r == cid_pkg::CID_CYC2);

    // table byte fetched from current page at acc offset
    always_comb begin
        prog_addr = pc_r;
        if (exec2 && op == `CID_OP_TABLE) begin
            prog_addr = {pc_r[PC_W-1:8], acc_r};
        end
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_r <= cid_pkg::CID_CYC1;
            op_r <= 8'h00;
        end else begin
            case (state_r)
                cid_pkg::CID_CYC1: begin
                    if (exec1 && two_cycle) begin
                        state_r <= cid_pkg::CID_CYC2;
                        op_r <= prog_data;
                    end
                end
                cid_pkg::CID_CYC2: begin
                    state_r <= cid_pkg::CID_CYC1;
                end
                default: state_r <= cid_pkg::CID_CYC1;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // program counter
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            pc_r <= '0;
        end else if (exec1) begin
            pc_r <= pc_inc;
        end else if (exec2) begin
            if (is_jump) begin
                // eleven bits from opcode and byte, top from latch
                pc_r <= {ctrl_r.bank, op[7:5], prog_data};
            end else if (op == `CID_OP_TABLE) begin
                pc_r <= {pc_r[PC_W-1:8], prog_data};
            end else if (cond_br && cond) begin
                // page of the second byte kept
                // pc already past a page-end opcode
                pc_r <= {pc_r[PC_W-1:8], prog_data};
            end else if (cond_br) begin
                // not taken skips the address byte
                pc_r <= pc_inc;
            end
            // single-byte reads hold pc: their second cycle fetches nothing
        end
    end

    // ----------------------------------------------------------------
    // accumulator
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            acc_r <= 8'h00;
        end else if (exec1 && op == `CID_OP_DEC_A) begin
            acc_r <= acc_r - 8'h01;
        end else if (exec1 && op == `CID_OP_INC_A) begin
            acc_r <= acc_r + 8'h01;
        end else if (exec2 && op == `CID_OP_PORT1) begin
            acc_r <= port1_in;
        end else if (exec2 && op == `CID_OP_PORT2) begin
            acc_r <= port2_in;
        end else if (exec2 && op == `CID_OP_BUS_RD) begin
            // latched on the edge that ends the strobe
            acc_r <= bus_in;
        end
    end
    assign acc_out = acc_r;

    // strobe low for the whole second cycle
    assign bus_rd_n = ~(exec2 && op_r == `CID_OP_BUS_RD);

    // ----------------------------------------------------------------
    // data memory; working registers are its first eight bytes
    // ----------------------------------------------------------------
    generate
        for (genvar i = 0; i < RAM_DEPTH; i++) begin : g_ram
            always_ff @(posedge mclk) begin
                if (rst) begin
                    ram_r[i] <= 8'h00;
                end else if (i < 8 && exec1 && is_dec_r
                        && reg_sel == i[2:0]) begin
                    ram_r[i] <= reg_dec;
                end else if (i < 8 && exec1 && is_inc_r
                        && reg_sel == i[2:0]) begin
                    ram_r[i] <= reg_val + 8'h01;
                end else if (i < 8 && exec2 && is_count_down_branch
                        && reg_sel == i[2:0]) begin
                    ram_r[i] <= reg_dec;
                end else if (exec1 && is_inc_ind
                        && ind_addr == i[5:0]) begin
                    ram_r[i] <= ram_r[i] + 8'h01;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // interrupt enables, pending timer request and timer flag
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_r.ext_en <= 1'b0;
        end else if (exec1 && op == `CID_OP_EXT_ON) begin
            irq_r.ext_en <= 1'b1;
        end else if (exec1 && op == `CID_OP_EXT_OFF) begin
            // low pin no longer raises irq_request
            irq_r.ext_en <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_r.tmr_en <= 1'b0;
        end else if (exec1 && op == `CID_OP_TMR_ON) begin
            irq_r.tmr_en <= 1'b1;
        end else if (exec1 && op == `CID_OP_TMR_OFF) begin
            irq_r.tmr_en <= 1'b0;
        end
    end

    // an overflow in the cycle of a clear still lands: set beats clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_r.tmr_pend <= 1'b0;
        end else if (timer_ovf && irq_r.tmr_en) begin
            irq_r.tmr_pend <= 1'b1;
        end else if ((exec1 && op == `CID_OP_TMR_OFF) || irq_ack) begin
            irq_r.tmr_pend <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_r.tmr_flag <= 1'b0;
        end else if (timer_ovf) begin
            irq_r.tmr_flag <= 1'b1;
        end else if (exec2 && op == `CID_OP_TF_BR) begin
            irq_r.tmr_flag <= 1'b0;
        end
    end

    assign irq_request = (irq_r.ext_en & ~irq_n)
        | (irq_r.tmr_en & irq_r.tmr_pend);

    // ----------------------------------------------------------------
    // test pin zero as clock output
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            // reset returns the pin to input
            irq_r.clk_out <= 1'b0;
        end else if (exec1 && op == `CID_OP_CLK_OUT) begin
            irq_r.clk_out <= 1'b1;
        end
    end

    // half rate keeps the output glitch-free from a flop
    always_ff @(posedge mclk) begin
        if (rst) begin
            clk_div_r <= 1'b0;
        end else begin
            clk_div_r <= ~clk_div_r;
        end
    end
    assign test_pin_zero_out = clk_div_r & irq_r.clk_out;
    assign test_pin_zero_oe = irq_r.clk_out;

    // ----------------------------------------------------------------
    // apb register file
    // ----------------------------------------------------------------
    assign pready = 1'b1;
    assign wr_ctrl = psel & penable & pwrite & (paddr == `CID_CTRL_OFF);
    assign rd_ok = (paddr == `CID_CTRL_OFF) | (paddr == `CID_STAT_OFF);
    assign pslverr = psel & penable & ~rd_ok;

    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_r <= cid_pkg::cid_ctrl_s'(`CID_CTRL_RST);
        end else if (wr_ctrl) begin
            ctrl_r.run <= pwdata[`CID_CTRL_RUN];
            ctrl_r.cy <= pwdata[`CID_CTRL_CY];
            ctrl_r.f0 <= pwdata[`CID_CTRL_F0];
            ctrl_r.f1 <= pwdata[`CID_CTRL_F1];
            ctrl_r.bank <= pwdata[`CID_CTRL_BANK];
        end
    end

    always_comb begin
        prdata = 32'h0000_0000;
        if (paddr == `CID_CTRL_OFF) begin
            prdata[`CID_CTRL_RUN] = ctrl_r.run;
            prdata[`CID_CTRL_CY] = ctrl_r.cy;
            prdata[`CID_CTRL_F0] = ctrl_r.f0;
            prdata[`CID_CTRL_F1] = ctrl_r.f1;
            prdata[`CID_CTRL_BANK] = ctrl_r.bank;
        end else if (paddr == `CID_STAT_OFF) begin
            prdata[7:0] = acc_r;
            prdata[`CID_STAT_EXT_EN] = irq_r.ext_en;
            prdata[`CID_STAT_TMR_EN] = irq_r.tmr_en;
            prdata[`CID_STAT_TMR_PEND] = irq_r.tmr_pend;
            prdata[`CID_STAT_TMR_FLAG] = irq_r.tmr_flag;
            prdata[`CID_STAT_CLK_OUT] = irq_r.clk_out;
            prdata[`CID_STAT_PC_LSB +: PC_W] = pc_r;
        end
    end

endmodule : cid_core

/* File: cid_core_asserts.sv */
// pin-side checks for the instruction slice core
// assumes one clock, mclk, and synchronous active-high rst
`timescale 1ns/1ps

module cid_core_asserts (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // program and bus side
    input wire logic [7:0] prog_data,
    input wire logic [7:0] bus_in,
    input wire logic bus_rd_n,
    // interrupt side
    input wire logic irq_n,
    input wire logic timer_ovf,
    input wire logic irq_ack,
    input wire logic irq_request,
    // test pin and state
    input wire logic test_pin_zero_out,
    input wire logic test_pin_zero_oe,
    input wire logic [7:0] acc_out
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // ----------------------------------------------------------------
    // strobe steps
    // ----------------------------------------------------------------
    sequence strobe_tail;
        !bus_rd_n ##1 bus_rd_n;
    endsequence

    strobe_pulse_a: assert property ($fell(bus_rd_n) |-> strobe_tail)
        else $error("read strobe not exactly one cycle");
    strobe_cause_a: assert property (!bus_rd_n |-> $past(prog_data) == 8'h08)
        else $error("read strobe without bus read opcode");
    bus_latch_a: assert property (!bus_rd_n |=> acc_out == $past(bus_in))
        else $error("bus byte not latched at strobe rise");
    clk_reset_off_a: assert property ($fell(rst) |-> !test_pin_zero_oe)
        else $error("clock output survives reset");
    clk_toggle_a: assert property (test_pin_zero_oe && $past(test_pin_zero_oe)
        |-> test_pin_zero_out != $past(test_pin_zero_out))
        else $error("test pin clock not toggling");
    irq_reset_off_a: assert property ($fell(rst)
        |-> !irq_request && bus_rd_n && acc_out == 8'h00)
        else $error("interrupt or state not cleared by reset");
    irq_rise_cause_a: assert property ($rose(irq_request)
        |-> !irq_n || $past(timer_ovf))
        else $error("interrupt request without cause");
    ack_clears_a: assert property (irq_ack && irq_n && !timer_ovf
        |=> !irq_request || !irq_n)
        else $error("acknowledge left timer request");
endmodule : cid_core_asserts

bind cid_core cid_core_asserts u_chk (.mclk(mclk), .rst(rst),
    .prog_data(prog_data), .bus_in(bus_in), .bus_rd_n(bus_rd_n),
    .irq_n(irq_n), .timer_ovf(timer_ovf), .irq_ack(irq_ack),
    .irq_request(irq_request), .test_pin_zero_out(test_pin_zero_out),
    .test_pin_zero_oe(test_pin_zero_oe), .acc_out(acc_out));

/* File: cid_far_model.sv */
// program memory and strobed bus device beside the slice core
// assumes the bench loads mem directly while the core is halted
`timescale 1ns/1ps

module cid_far_model (
    // clock
    input wire logic mclk,
    // program memory
    input wire logic [11:0] prog_addr,
    output logic [7:0] prog_data,
    // strobed bus device
    input wire logic bus_rd_n,
    output logic [7:0] bus_in
);
    logic [7:0] mem [0:4095];
    logic [7:0] bus_val;
    logic [7:0] junk_r;

    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        bus_val = 8'hC3;
        junk_r = 8'h00;
    end

    assign prog_data = mem[prog_addr];

    // released bus flips every cycle so a stale byte never passes
    always @(posedge mclk) junk_r <= ~junk_r;

    assign bus_in = bus_rd_n ? junk_r : bus_val;
endmodule : cid_far_model

/* File: cid_core_tb.sv */
// self-checking bench for the slice core, programs run from the model
// assumes cid_params.svh on the include path
`timescale 1ns/1ps
`include "cid_params.svh"

module cid_core_tb;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [7:0] port1_in = 8'hA5;
    logic [7:0] port2_in = 8'h5A;
    logic irq_n = 1'b1;
    logic timer_ovf = 1'b0;
    logic irq_ack = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, bus_rd_n, irq_request, t0_out, t0_oe, t;
    logic [11:0] prog_addr;
    logic [7:0] prog_data, bus_in, acc_out;
    logic [31:0] rdat;
    logic rerr;
    logic [11:0] cur = 12'h00E;
    logic [11:0] sb = 12'h600;
    logic [7:0] ops [0:2] = '{8'h08, 8'h0A, 8'h09};
    logic [7:0] exps [0:2] = '{8'hC3, 8'h5A, 8'hA5};
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;

    always #20 mclk = ~mclk;

    cid_core dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .prog_addr(prog_addr),
        .prog_data(prog_data), .port1_in(port1_in), .port2_in(port2_in),
        .bus_in(bus_in), .bus_rd_n(bus_rd_n), .irq_n(irq_n),
        .timer_ovf(timer_ovf), .irq_ack(irq_ack), .irq_request(irq_request),
        .test_pin_zero_in(1'b0), .test_pin_zero_out(t0_out),
        .test_pin_zero_oe(t0_oe), .acc_out(acc_out));

    cid_far_model u_far (.mclk(mclk), .prog_addr(prog_addr),
        .prog_data(prog_data), .bus_rd_n(bus_rd_n), .bus_in(bus_in));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task end_sim;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim

    always @(posedge mclk) begin
        cycles++;
        if (cycles > 20000) begin
            mismatches++;
            end_sim();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task jmp_at(input logic [11:0] a, input logic [11:0] tg);
        u_far.mem[a] = {tg[10:8], 5'h04};
        u_far.mem[a + 12'h001] = tg[7:0];
    endtask : jmp_at

    // halting lands on the loop's own jump, so pc reads back exactly
    task go(input logic [11:0] start, input logic [4:0] ctl,
            input logic [11:0] exp);
        jmp_at(cur, start);
        apb(1'b1, `CID_CTRL_OFF, {27'h0, ctl | 5'h01});
        repeat (40) @(posedge mclk);
        apb(1'b1, `CID_CTRL_OFF, {27'h0, ctl});
        apb(1'b0, `CID_STAT_OFF, 32'h0);
        chk({20'h0, rdat[`CID_STAT_PC_LSB +: 12]}, {20'h0, exp});
        cur = exp;
        sb = sb ^ 12'h100;
        $display("test ended at pc %h", exp);
    endtask : go

    task br(input logic [7:0] op, input logic [4:0] ctl, input logic tk);
        u_far.mem[sb] = op;
        u_far.mem[sb + 12'h001] = 8'h20;
        jmp_at(sb + 12'h002, sb + 12'h002);
        jmp_at(sb + 12'h020, sb + 12'h020);
        go(sb, ctl, tk ? sb + 12'h020 : sb + 12'h002);
    endtask : br

    task pulse_ovf;
        timer_ovf <= 1'b1;
        @(posedge mclk);
        timer_ovf <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask : pulse_ovf

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        apb(1'b0, `CID_CTRL_OFF, 32'h0);
        chk(rdat, `CID_CTRL_RST);
        apb(1'b0, 12'h008, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        chk(rdat, 32'h0);
        u_far.mem[0] = `CID_OP_DEC_A;
        u_far.mem[1] = `CID_OP_INC_A;
        u_far.mem[2] = `CID_OP_INC_A;
        jmp_at(12'h003, 12'h003);
        go(12'h000, 5'h00, 12'h003);
        chk(rdat & 32'hFF, 32'h01);
        u_far.mem[12'h2FD] = 8'h1B;
        u_far.mem[12'h2FE] = 8'h1B;
        u_far.mem[12'h2FF] = 8'hEB;
        u_far.mem[12'h300] = 8'h10;
        jmp_at(12'h301, 12'h301);
        jmp_at(12'h310, 12'h310);
        go(12'h2FD, 5'h00, 12'h310);
        go(12'h2FF, 5'h00, 12'h301);
        // r0 steps to 1 through itself, then r1 through r0
        u_far.mem[sb] = 8'h10;
        u_far.mem[sb + 12'h001] = 8'h10;
        u_far.mem[sb + 12'h002] = 8'hC8;
        u_far.mem[sb + 12'h003] = 8'hE9;
        u_far.mem[sb + 12'h004] = 8'h30;
        u_far.mem[sb + 12'h005] = 8'hE8;
        u_far.mem[sb + 12'h006] = 8'h20;
        jmp_at(sb + 12'h007, sb + 12'h007);
        jmp_at(sb + 12'h020, sb + 12'h020);
        jmp_at(sb + 12'h030, sb + 12'h030);
        go(sb, 5'h00, sb + 12'h020);
        for (int i = 0; i < 3; i++) begin
            u_far.mem[sb] = ops[i];
            jmp_at(sb + 12'h001, sb + 12'h001);
            go(sb, 5'h00, sb + 12'h001);
            chk(rdat & 32'hFF, {24'h0, exps[i]});
        end
        u_far.mem[sb] = `CID_OP_TABLE;
        u_far.mem[{sb[11:8], 8'hA5}] = 8'h50;
        jmp_at({sb[11:8], 8'h50}, {sb[11:8], 8'h50});
        go(sb, 5'h00, {sb[11:8], 8'h50});
        for (int i = 0; i < 8; i++) begin
            br({i[2:0], 5'h12}, 5'h00, port1_in[i]);
        end
        br(`CID_OP_CY_SET, 5'h02, 1'b1);
        br(`CID_OP_CY_SET, 5'h00, 1'b0);
        br(`CID_OP_CY_CLR, 5'h00, 1'b1);
        br(`CID_OP_CY_CLR, 5'h02, 1'b0);
        br(`CID_OP_F0_BR, 5'h04, 1'b1);
        br(`CID_OP_F0_BR, 5'h08, 1'b0);
        br(`CID_OP_F1_BR, 5'h08, 1'b1);
        br(`CID_OP_F1_BR, 5'h04, 1'b0);
        irq_n <= 1'b0;
        br(`CID_OP_IRQ_BR, 5'h00, 1'b1);
        irq_n <= 1'b1;
        br(`CID_OP_IRQ_BR, 5'h00, 1'b0);
        u_far.mem[12'h810] = 8'h24;
        u_far.mem[12'h811] = 8'h40;
        jmp_at(12'h940, 12'h940);
        go(12'h810, 5'h10, 12'h940);
        u_far.mem[sb] = `CID_OP_EXT_ON;
        u_far.mem[sb + 12'h001] = `CID_OP_TMR_ON;
        u_far.mem[sb + 12'h002] = `CID_OP_CLK_OUT;
        jmp_at(sb + 12'h003, sb + 12'h003);
        go(sb, 5'h00, sb + 12'h003);
        chk({27'h0, rdat[12:8]}, 32'h13);
        chk({31'h0, irq_request}, 32'h0);
        irq_n <= 1'b0;
        repeat (2) @(posedge mclk);
        chk({31'h0, irq_request}, 32'h1);
        irq_n <= 1'b1;
        pulse_ovf();
        chk({31'h0, irq_request}, 32'h1);
        irq_ack <= 1'b1;
        @(posedge mclk);
        irq_ack <= 1'b0;
        repeat (2) @(posedge mclk);
        chk({31'h0, irq_request}, 32'h0);
        chk({31'h0, t0_oe}, 32'h1);
        t = t0_out;
        @(posedge mclk);
        chk({31'h0, t0_out}, {31'h0, ~t});
        // leave a pending timer request for the disable to drop
        pulse_ovf();
        chk({31'h0, irq_request}, 32'h1);
        u_far.mem[sb] = `CID_OP_EXT_OFF;
        u_far.mem[sb + 12'h001] = `CID_OP_TMR_OFF;
        jmp_at(sb + 12'h002, sb + 12'h002);
        go(sb, 5'h00, sb + 12'h002);
        chk({31'h0, rdat[`CID_STAT_TMR_PEND]}, 32'h0);
        irq_n <= 1'b0;
        pulse_ovf();
        chk({31'h0, irq_request}, 32'h0);
        apb(1'b0, `CID_STAT_OFF, 32'h0);
        chk({30'h0, rdat[11:10]}, 32'h2);
        irq_n <= 1'b1;
        br(`CID_OP_TF_BR, 5'h00, 1'b1);
        chk({31'h0, rdat[`CID_STAT_TMR_FLAG]}, 32'h0);
        br(`CID_OP_TF_BR, 5'h00, 1'b0);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        chk({23'h0, t0_oe, acc_out}, 32'h0);
        end_sim();
    end
endmodule : cid_core_tb
